// File: logic/fcs_pkg.sv
// constants shared by the flash command and status unit
package fcs_pkg;
    // ************************************************************
    // register map (byte addresses, one aligned word each)
    // ************************************************************
    localparam logic [7:0] ADDR_STATUS = 8'h00;
    localparam logic [7:0] ADDR_COMMAND = 8'h04;
    localparam logic [7:0] ADDR_DIVIDER = 8'h08;
    localparam logic [7:0] ADDR_PROTECT = 8'h0C;
    localparam logic [7:0] ADDR_IRQ_STATUS = 8'h10;
    localparam logic [7:0] ADDR_IRQ_MASK = 8'h14;
    localparam logic [7:0] ADDR_SECURITY = 8'h18;
    localparam logic [7:0] ADDR_TARGET = 8'h1C;
    // ************************************************************
    // status field positions
    // ************************************************************
    localparam int BIT_CBEF = 7;
    localparam int BIT_CCF = 6;
    localparam int BIT_PVIOL = 5;
    localparam int BIT_ACCERR = 4;
    localparam int BIT_BLANK = 2;
    // irq status layout
    localparam int IRQ_DONE = 0;
    localparam int IRQ_PVIOL = 1;
    localparam int IRQ_ACCERR = 2;
    // ************************************************************
    // command codes
    // ************************************************************
    localparam logic [7:0] CMD_BLANK = 8'h05;
    localparam logic [7:0] CMD_BYTE_PROG = 8'h20;
    localparam logic [7:0] CMD_BURST_PROG = 8'h25;
    localparam logic [7:0] CMD_PAGE_ERASE = 8'h40;
    localparam logic [7:0] CMD_MASS_ERASE = 8'h41;
    // ************************************************************
    // reset values, security codes, erased byte value and page size
    // ************************************************************
    localparam logic [7:0] RST_COMMAND = 8'h00;
    localparam logic [7:0] RST_PROTECT = 8'h00;
    localparam logic [1:0] SEC_SECURE = 2'h0;
    localparam logic [1:0] SEC_UNSECURED = 2'h2;
    localparam logic [7:0] ERASED_BYTE = 8'hFF;
    localparam int PAGE_BYTES = 512;
    // array operation time in bus cycles
    localparam int OP_CYCLES = 8;
endpackage

// File: logic/fcs_top.sv
// flash command launch and status unit with AXI4-Lite register access
`timescale 1ns/1ps
module fcs_top #(
    parameter int ADDR_W = 14,
    parameter int OP_CYC = fcs_pkg::OP_CYCLES
) (
    input wire logic I_CORE_CLK,
    input wire logic I_SYS_RST,
    input wire logic I_STOP_MODE,
    input wire logic I_ARRAY_BLANK,
    input wire logic [7:0] I_AWADDR,
    input wire logic I_AWVALID,
    output logic O_AWREADY,
    input wire logic [31:0] I_WDATA,
    input wire logic [3:0] I_WSTRB,
    input wire logic I_WVALID,
    output logic O_WREADY,
    output logic [1:0] O_BRESP,
    output logic O_BVALID,
    input wire logic I_BREADY,
    input wire logic [7:0] I_ARADDR,
    input wire logic I_ARVALID,
    output logic O_ARREADY,
    output logic [31:0] O_RDATA,
    output logic [1:0] O_RRESP,
    output logic O_RVALID,
    input wire logic I_RREADY,
    output logic O_ARRAY_START,
    output logic [7:0] O_ARRAY_CMD,
    output logic [ADDR_W-1:0] O_ARRAY_ADDR,
    output logic [7:0] O_ARRAY_DATA,
    output logic [1:0] O_SECURITY,
    output logic O_IRQ
);
    // refuse sizes that the target field, the read word or the run counter cannot hold
    if (ADDR_W < 10 || ADDR_W > 23) begin : g_addr_w_chk
        $error("ADDR_W out of range");
    end
    if (OP_CYC < 1 || OP_CYC > 255) begin : g_op_cyc_chk
        $error("OP_CYC out of range");
    end

    // ************************************************************
    // AXI4-Lite slave
    // ************************************************************
    logic aw_got_q, w_got_q;
    logic [7:0] aw_addr_q;
    logic [31:0] w_data_q;
    logic [3:0] w_strb_q;
    logic wr_fire;
    logic rd_fire;
    logic [31:0] rd_word;
    logic [1:0] rd_resp;

    assign wr_fire = aw_got_q && w_got_q && !O_BVALID;
    assign rd_fire = I_ARVALID && O_ARREADY;

    // address and data accepted independently, answer after both
    always_ff @(posedge I_CORE_CLK) begin
        if (I_SYS_RST) begin
            aw_got_q <= 1'b0;
            w_got_q <= 1'b0;
            aw_addr_q <= 8'h00;
            w_data_q <= 32'h0000_0000;
            w_strb_q <= 4'h0;
            O_AWREADY <= 1'b0;
            O_WREADY <= 1'b0;
        end else begin
            O_AWREADY <= !aw_got_q && !(I_AWVALID && O_AWREADY);
            O_WREADY <= !w_got_q && !(I_WVALID && O_WREADY);
            if (I_AWVALID && O_AWREADY) begin
                aw_got_q <= 1'b1;
                aw_addr_q <= I_AWADDR;
            end else if (wr_fire) begin
                aw_got_q <= 1'b0;
            end
            if (I_WVALID && O_WREADY) begin
                w_got_q <= 1'b1;
                w_data_q <= I_WDATA;
                w_strb_q <= I_WSTRB;
            end else if (wr_fire) begin
                w_got_q <= 1'b0;
            end
        end
    end

    // write response
    always_ff @(posedge I_CORE_CLK) begin
        if (I_SYS_RST) begin
            O_BVALID <= 1'b0;
            O_BRESP <= 2'h0;
        end else if (wr_fire) begin
            O_BVALID <= 1'b1;
            O_BRESP <= (aw_addr_q > fcs_pkg::ADDR_TARGET || aw_addr_q[1:0] != 2'h0)
                ? 2'h2 : 2'h0;
        end else if (I_BREADY) begin
            O_BVALID <= 1'b0;
        end
    end

    // write strobes per register, low byte lane carries 8-bit registers
    logic wr_lo;
    assign wr_lo = wr_fire && w_strb_q[0];
    logic wr_stat, wr_cmd, wr_div, wr_prot, wr_isr, wr_imsk, wr_tgt;
    assign wr_stat = wr_lo && aw_addr_q == fcs_pkg::ADDR_STATUS;
    assign wr_cmd = wr_lo && aw_addr_q == fcs_pkg::ADDR_COMMAND;
    assign wr_div = wr_lo && aw_addr_q == fcs_pkg::ADDR_DIVIDER;
    assign wr_prot = wr_lo && aw_addr_q == fcs_pkg::ADDR_PROTECT;
    assign wr_isr = wr_lo && aw_addr_q == fcs_pkg::ADDR_IRQ_STATUS;
    assign wr_imsk = wr_lo && aw_addr_q == fcs_pkg::ADDR_IRQ_MASK;
    assign wr_tgt = wr_fire && aw_addr_q == fcs_pkg::ADDR_TARGET;

    // ************************************************************
    // command registers and sequence tracking
    // ************************************************************
    logic [7:0] cmd_q, div_q, prot_q;
    logic div_set_q;
    logic tgt_set_q, cmd_set_q;
    logic [ADDR_W-1:0] tgt_addr_q;
    logic [7:0] tgt_data_q;
    logic cbef_q, ccf_q, pviol_q, accerr_q, blank_q;
    logic busy_q;
    logic [7:0] op_cnt_q;
    logic [7:0] run_cmd_q;
    logic [1:0] sec_q;
    logic [2:0] isr_q, imsk_q;

    // decode of the pending command
    logic launch, code_ok, is_pe, is_burst, prot_hit, seq_bad, div_bad, accepted;
    logic ch_pv, ch_ae;
    assign launch = wr_stat && w_data_q[fcs_pkg::BIT_CBEF] && cbef_q;
    always_comb begin
        code_ok = 1'b0;
        case (cmd_q)
            fcs_pkg::CMD_BLANK, fcs_pkg::CMD_BYTE_PROG, fcs_pkg::CMD_BURST_PROG: begin
                code_ok = 1'b1;
            end
            fcs_pkg::CMD_PAGE_ERASE, fcs_pkg::CMD_MASS_ERASE: begin
                code_ok = 1'b1;
            end
            default: begin
                code_ok = 1'b0;
            end
        endcase
    end
    assign is_pe = cmd_q != fcs_pkg::CMD_BLANK;
    assign is_burst = cmd_q == fcs_pkg::CMD_BURST_PROG;
    // protected region: top addresses from prot_q*512 upward (zero disables)
    assign prot_hit = is_pe && prot_q != 8'h00 && (cmd_q == fcs_pkg::CMD_MASS_ERASE
        || tgt_addr_q[ADDR_W-1:9] >= (ADDR_W-9)'(prot_q));
    // a buffered launch during a run is legal only for burst after burst
    assign seq_bad = !tgt_set_q || !cmd_set_q || !code_ok
        || (busy_q && !(is_burst && run_cmd_q == fcs_pkg::CMD_BURST_PROG));
    assign div_bad = is_pe && !div_set_q;
    assign ch_ae = launch && (seq_bad || div_bad);
    assign ch_pv = launch && !ch_ae && prot_hit;
    assign accepted = launch && !ch_ae && !prot_hit;

    // software registers
    always_ff @(posedge I_CORE_CLK) begin
        if (I_SYS_RST) begin
            cmd_q <= fcs_pkg::RST_COMMAND;
            div_q <= 8'h00;
            div_set_q <= 1'b0;
            prot_q <= fcs_pkg::RST_PROTECT;
            imsk_q <= 3'h0;
        end else begin
            if (wr_cmd) cmd_q <= w_data_q[7:0];
            if (wr_div) begin
                div_q <= w_data_q[7:0];
                div_set_q <= 1'b1;
            end
            if (wr_prot) prot_q <= w_data_q[7:0];
            if (wr_imsk) imsk_q <= w_data_q[2:0];
        end
    end

    // target then command must both precede a launch
    always_ff @(posedge I_CORE_CLK) begin
        if (I_SYS_RST) begin
            tgt_set_q <= 1'b0;
            cmd_set_q <= 1'b0;
            tgt_addr_q <= '0;
            tgt_data_q <= 8'h00;
        end else if (launch) begin
            tgt_set_q <= 1'b0;
            cmd_set_q <= 1'b0;
        end else begin
            if (wr_tgt) begin
                tgt_addr_q <= w_data_q[8 +: ADDR_W];
                tgt_data_q <= w_data_q[7:0];
                tgt_set_q <= 1'b1;
                cmd_set_q <= 1'b0;
            end
            if (wr_cmd) cmd_set_q <= tgt_set_q; // command before target is a bad order
        end
    end

    // ************************************************************
    // execution: one running, one buffered burst
    // ************************************************************
    logic buf_full_q;
    logic op_end;
    assign op_end = busy_q && op_cnt_q == 8'h01;
    always_ff @(posedge I_CORE_CLK) begin
        if (I_SYS_RST) begin
            busy_q <= 1'b0;
            buf_full_q <= 1'b0;
            op_cnt_q <= 8'h00;
            run_cmd_q <= 8'h00;
            O_ARRAY_START <= 1'b0;
            O_ARRAY_CMD <= 8'h00;
            O_ARRAY_ADDR <= '0;
            O_ARRAY_DATA <= 8'h00;
        end else begin
            O_ARRAY_START <= 1'b0;
            if (I_STOP_MODE && busy_q) begin
                busy_q <= 1'b0;
                buf_full_q <= 1'b0;
            end else if (accepted && !busy_q) begin
                busy_q <= 1'b1;
                op_cnt_q <= 8'(OP_CYC);
                run_cmd_q <= cmd_q;
                O_ARRAY_START <= 1'b1;
                O_ARRAY_CMD <= cmd_q;
                O_ARRAY_ADDR <= tgt_addr_q;
                O_ARRAY_DATA <= tgt_data_q;
            end else if (busy_q) begin
                if (accepted) buf_full_q <= 1'b1;
                if (op_end && (buf_full_q || accepted)) begin
                    op_cnt_q <= 8'(OP_CYC); // buffered burst moves to the array
                    buf_full_q <= 1'b0;
                    O_ARRAY_START <= 1'b1;
                    O_ARRAY_CMD <= cmd_q;
                    O_ARRAY_ADDR <= tgt_addr_q;
                    O_ARRAY_DATA <= tgt_data_q;
                end else if (op_end) begin
                    busy_q <= 1'b0;
                end else begin
                    op_cnt_q <= op_cnt_q - 8'h01;
                end
            end
        end
    end

    // ************************************************************
    // status flags
    // ************************************************************
    // buffer empty drops on an accepted launch, except a burst launched while idle, and rises when the buffer is free again
    always_ff @(posedge I_CORE_CLK) begin
        if (I_SYS_RST) begin
            cbef_q <= 1'b1;
        end else if (accepted) begin
            cbef_q <= !busy_q && is_burst ? 1'b1 : 1'b0;
        end else if (op_end || (I_STOP_MODE && busy_q)) begin
            cbef_q <= 1'b1;
        end
    end
    // complete follows idle with empty buffer
    always_ff @(posedge I_CORE_CLK) begin
        if (I_SYS_RST) begin
            ccf_q <= 1'b1;
        end else if (accepted) begin
            ccf_q <= 1'b0;
        end else begin
            ccf_q <= !busy_q || (I_STOP_MODE) || (op_end && !buf_full_q);
        end
    end
    // error flags: set beats a same-cycle clear
    always_ff @(posedge I_CORE_CLK) begin
        if (I_SYS_RST) begin
            pviol_q <= 1'b0;
            accerr_q <= 1'b0;
        end else begin
            if (ch_pv) pviol_q <= 1'b1;
            else if (wr_stat && w_data_q[fcs_pkg::BIT_PVIOL]) pviol_q <= 1'b0;
            if (ch_ae || (I_STOP_MODE && busy_q)) accerr_q <= 1'b1;
            else if (wr_stat && w_data_q[fcs_pkg::BIT_ACCERR]) accerr_q <= 1'b0;
        end
    end
    // blank result and security state
    always_ff @(posedge I_CORE_CLK) begin
        if (I_SYS_RST) begin
            blank_q <= 1'b0;
            sec_q <= fcs_pkg::SEC_SECURE;
        end else if (accepted) begin
            blank_q <= 1'b0;
        end else if (op_end && run_cmd_q == fcs_pkg::CMD_BLANK && I_ARRAY_BLANK) begin
            blank_q <= 1'b1;
            sec_q <= fcs_pkg::SEC_UNSECURED;
        end
    end

    // ************************************************************
    // interrupts: sticky, write one to clear, set wins
    // ************************************************************
    logic [2:0] isr_set;
    assign isr_set = {ch_ae || (I_STOP_MODE && busy_q), ch_pv, op_end && !buf_full_q};
    always_ff @(posedge I_CORE_CLK) begin
        if (I_SYS_RST) begin
            isr_q <= 3'h0;
            O_IRQ <= 1'b0;
        end else begin
            isr_q <= isr_set | (isr_q & ~(wr_isr ? w_data_q[2:0] : 3'h0));
            O_IRQ <= |(isr_q & imsk_q);
        end
    end
    assign O_SECURITY = sec_q;

    // ************************************************************
    // read channel
    // ************************************************************
    always_comb begin
        rd_resp = 2'h0;
        case (I_ARADDR)
            fcs_pkg::ADDR_STATUS: rd_word = {24'h0, cbef_q, ccf_q, pviol_q, accerr_q,
                1'b0, blank_q, 2'b00};
            fcs_pkg::ADDR_COMMAND: rd_word = {24'h0, cmd_q};
            fcs_pkg::ADDR_DIVIDER: rd_word = {24'h0, div_q};
            fcs_pkg::ADDR_PROTECT: rd_word = {24'h0, prot_q};
            fcs_pkg::ADDR_IRQ_STATUS: rd_word = {29'h0, isr_q};
            fcs_pkg::ADDR_IRQ_MASK: rd_word = {29'h0, imsk_q};
            fcs_pkg::ADDR_SECURITY: rd_word = {30'h0, sec_q};
            fcs_pkg::ADDR_TARGET: rd_word = {(24-ADDR_W)'(0), tgt_addr_q, tgt_data_q};
            default: begin
                rd_word = 32'h0000_0000;
                rd_resp = 2'h2;
            end
        endcase
    end
    always_ff @(posedge I_CORE_CLK) begin
        if (I_SYS_RST) begin
            O_ARREADY <= 1'b0;
            O_RVALID <= 1'b0;
            O_RDATA <= 32'h0000_0000;
            O_RRESP <= 2'h0;
        end else begin
            O_ARREADY <= !O_RVALID && !rd_fire;
            if (rd_fire) begin
                O_RVALID <= 1'b1;
                O_RDATA <= rd_word;
                O_RRESP <= rd_resp;
            end else if (I_RREADY) begin
                O_RVALID <= 1'b0;
            end
        end
    end

    // ************************************************************
    // checks
    // ************************************************************
    launch_clr_a: assert property (@(posedge I_CORE_CLK) disable iff (I_SYS_RST)
        accepted |=> !ccf_q) else $error("complete flag not cleared on launch");
    pviol_set_a: assert property (@(posedge I_CORE_CLK) disable iff (I_SYS_RST)
        ch_pv |=> pviol_q && !O_ARRAY_START) else $error("violation not flagged");
    pviol_hold_a: assert property (@(posedge I_CORE_CLK) disable iff (I_SYS_RST)
        $fell(pviol_q) |-> $past(wr_stat)) else $error("violation cleared wrongly");
    accerr_set_a: assert property (@(posedge I_CORE_CLK) disable iff (I_SYS_RST)
        ch_ae |=> accerr_q && !O_ARRAY_START) else $error("access error missed");
    stop_err_a: assert property (@(posedge I_CORE_CLK) disable iff (I_SYS_RST)
        I_STOP_MODE && busy_q |=> accerr_q && !busy_q) else $error("stop not flagged");
    accerr_hold_a: assert property (@(posedge I_CORE_CLK) disable iff (I_SYS_RST)
        $fell(accerr_q) |-> $past(wr_stat)) else $error("access error cleared");
    blank_set_a: assert property (@(posedge I_CORE_CLK) disable iff (I_SYS_RST)
        $rose(blank_q) |-> $past(run_cmd_q) == fcs_pkg::CMD_BLANK && sec_q == 2'h2)
        else $error("blank flag without blank check");
    stat_zero_a: assert property (@(posedge I_CORE_CLK) disable iff (I_SYS_RST)
        O_RVALID && $past(rd_fire) && $past(I_ARADDR) == fcs_pkg::ADDR_STATUS
        |-> O_RDATA[3] == 1'b0 && O_RDATA[1:0] == 2'b00) else $error("reserved bits");
    illegal_a: assert property (@(posedge I_CORE_CLK) disable iff (I_SYS_RST)
        launch && !code_ok |=> accerr_q ##1 !busy_q || O_ARRAY_CMD != $past(cmd_q, 2))
        else $error("illegal code ran");
    // cycles since the last start pulse; counting keeps the run check cheap for long runs
    logic [7:0] run_len_q;
    always_ff @(posedge I_CORE_CLK) begin
        if (I_SYS_RST) begin
            run_len_q <= 8'h00;
        end else if (O_ARRAY_START) begin
            run_len_q <= 8'h01;
        end else if (busy_q) begin
            run_len_q <= run_len_q + 8'h01;
        end
    end
    run_len_a: assert property (@(posedge I_CORE_CLK) disable iff (I_SYS_RST)
        op_end && !O_ARRAY_START |-> run_len_q == 8'(OP_CYC - 1))
        else $error("operation length");
    cov_run_c: cover property (@(posedge I_CORE_CLK) accepted ##[1:300] ccf_q);
    cov_burst_c: cover property (@(posedge I_CORE_CLK) busy_q && accepted);
    cov_pv_c: cover property (@(posedge I_CORE_CLK) ch_pv);
    cov_blank_c: cover property (@(posedge I_CORE_CLK) $rose(blank_q));
endmodule

// File: verif/fcs_array_model.sv
// flash array model answering the command unit's start pulses
`timescale 1ns/1ps
module fcs_array_model (
    input wire logic i_clk,
    input wire logic i_rst,
    input wire logic i_start,
    input wire logic [7:0] i_cmd,
    input wire logic [7:0] i_data,
    output logic o_blank
);
    // content is unknown after reset, so the array starts as not blank
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            o_blank <= 1'b0;
        end else if (i_start && i_cmd == fcs_pkg::CMD_MASS_ERASE) begin
            o_blank <= 1'b1;
        end else if (i_start && i_cmd[7:4] == 4'h2 && i_data != fcs_pkg::ERASED_BYTE) begin
            o_blank <= 1'b0;
        end
    end
endmodule

// File: verif/fcs_top_test.sv
// self-checking bench for the flash command and status unit
`timescale 1ns/1ps
module fcs_top_test;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic stop = 1'b0;
    logic blank;
    logic [7:0] awaddr = 8'h00;
    logic [7:0] araddr = 8'h00;
    logic [31:0] wdata = 32'h0;
    logic awvalid = 1'b0;
    logic wvalid = 1'b0;
    logic bready = 1'b0;
    logic arvalid = 1'b0;
    logic rready = 1'b0;
    logic awrdy, wrdy, bvld, arrdy, rvld, start, irq;
    logic [1:0] bresp, rresp, sec;
    logic [31:0] rdata;
    logic [7:0] acmd, adata;
    logic [13:0] aaddr;
    int bad_count = 0;
    int num_checks = 0;
    int starts = 0;
    // long run time so a second burst can be queued while the first runs
    fcs_top #(.ADDR_W(14), .OP_CYC(40)) i_fcs_top (.I_CORE_CLK(clk), .I_SYS_RST(rst),
        .I_STOP_MODE(stop), .I_ARRAY_BLANK(blank), .I_AWADDR(awaddr), .I_AWVALID(awvalid),
        .O_AWREADY(awrdy), .I_WDATA(wdata), .I_WSTRB(4'hF), .I_WVALID(wvalid), .O_WREADY(wrdy),
        .O_BRESP(bresp), .O_BVALID(bvld), .I_BREADY(bready), .I_ARADDR(araddr),
        .I_ARVALID(arvalid), .O_ARREADY(arrdy), .O_RDATA(rdata), .O_RRESP(rresp),
        .O_RVALID(rvld), .I_RREADY(rready), .O_ARRAY_START(start), .O_ARRAY_CMD(acmd),
        .O_ARRAY_ADDR(aaddr), .O_ARRAY_DATA(adata), .O_SECURITY(sec), .O_IRQ(irq));
    fcs_array_model i_fcs_array_model (.i_clk(clk), .i_rst(rst), .i_start(start),
        .i_cmd(acmd), .i_data(adata), .o_blank(blank));
    always #5 clk = ~clk;
    // count array operations so refused commands can be seen as no-ops
    always @(posedge clk) if (start === 1'b1) starts <= starts + 1;
    // ************************************************************
    // bus tasks
    // ************************************************************
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        num_checks++;
        if (seen !== exp) begin
            bad_count++;
            $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    // valid and payload held until each ready; the trailing edge avoids double drives
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        int n = 0;
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        do begin
            @(posedge clk);
            n++;
            if (awrdy) awvalid <= 1'b0;
            if (wrdy) wvalid <= 1'b0;
        end while (bvld !== 1'b1 && n < 60);
        bready <= 1'b0;
        @(posedge clk);
        if (n >= 60) bad_count++;
    endtask
    task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
        int n = 0;
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        do begin
            @(posedge clk);
            n++;
            if (arrdy) arvalid <= 1'b0;
        end while (rvld !== 1'b1 && n < 60);
        d = rdata;
        r = rresp;
        rready <= 1'b0;
        @(posedge clk);
        if (n >= 60) bad_count++;
    endtask
    task automatic rchk(input logic [7:0] a, input logic [31:0] exp);
        logic [31:0] d;
        logic [1:0] r;
        rd(a, d, r);
        chk(d, exp);
    endtask
    task automatic launch(input logic [7:0] c, input logic [31:0] tgt);
        wr(fcs_pkg::ADDR_TARGET, tgt);
        wr(fcs_pkg::ADDR_COMMAND, {24'h0, c});
        wr(fcs_pkg::ADDR_STATUS, 32'h80);
    endtask
    // poll the complete flag instead of assuming the run length
    task automatic wait_done;
        logic [31:0] d;
        logic [1:0] r;
        int n = 0;
        do begin
            rd(fcs_pkg::ADDR_STATUS, d, r);
            n++;
        end while (d[fcs_pkg::BIT_CCF] !== 1'b1 && n < 60);
        if (n >= 60) bad_count++;
    endtask
    task automatic give_verdict;
        $display("checks %0d mismatches %0d", num_checks, bad_count);
        if (bad_count == 0 && num_checks > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask
    // ************************************************************
    // scenarios
    // ************************************************************
    task automatic t_reset;
        logic [31:0] d;
        logic [1:0] r;
        rchk(fcs_pkg::ADDR_STATUS, 32'hC0);
        wr(fcs_pkg::ADDR_STATUS, 32'h4F);
        rchk(fcs_pkg::ADDR_STATUS, 32'hC0);
        rd(8'h40, d, r);
        chk({30'h0, r}, 32'h2);
        chk(d, 32'h0);
        $display("reset test done");
    endtask
    task automatic t_errors;
        int s = starts;
        logic [7:0] codes[3] = '{8'h00, 8'h21, 8'h42};
        launch(fcs_pkg::CMD_BYTE_PROG, 32'h0001_0000);
        rchk(fcs_pkg::ADDR_STATUS, 32'hD0);
        wr(fcs_pkg::ADDR_STATUS, 32'h00);
        rchk(fcs_pkg::ADDR_STATUS, 32'hD0);
        wr(fcs_pkg::ADDR_STATUS, 32'h10);
        rchk(fcs_pkg::ADDR_STATUS, 32'hC0);
        wr(fcs_pkg::ADDR_DIVIDER, 32'h1);
        wr(fcs_pkg::ADDR_IRQ_MASK, 32'h4);
        foreach (codes[i]) begin
            launch(codes[i], 32'h0);
            rchk(fcs_pkg::ADDR_STATUS, 32'hD0);
            chk({31'h0, irq}, 32'h1);
            wr(fcs_pkg::ADDR_STATUS, 32'h10);
            wr(fcs_pkg::ADDR_IRQ_STATUS, 32'h7);
            chk({31'h0, irq}, 32'h0);
        end
        wr(fcs_pkg::ADDR_IRQ_MASK, 32'h0);
        // command and launch without the target write breaks the sequence
        wr(fcs_pkg::ADDR_COMMAND, {24'h0, fcs_pkg::CMD_BYTE_PROG});
        wr(fcs_pkg::ADDR_STATUS, 32'h80);
        rchk(fcs_pkg::ADDR_STATUS, 32'hD0);
        chk({31'h0, irq}, 32'h0);
        chk(32'(starts), 32'(s));
        wr(fcs_pkg::ADDR_STATUS, 32'h10);
        $display("error test done");
    endtask
    task automatic t_blank;
        int s = starts;
        launch(fcs_pkg::CMD_MASS_ERASE, 32'h0);
        wait_done;
        launch(fcs_pkg::CMD_BLANK, 32'h0);
        wait_done;
        rchk(fcs_pkg::ADDR_STATUS, 32'hC4);
        rchk(fcs_pkg::ADDR_SECURITY, 32'h2);
        chk({30'h0, sec}, {30'h0, fcs_pkg::SEC_UNSECURED});
        chk(32'(starts), 32'(s + 2));
        launch(fcs_pkg::CMD_BYTE_PROG, 32'h0001_0000);
        // a running byte program leaves no room for a buffered burst
        rchk(fcs_pkg::ADDR_STATUS, 32'h00);
        wait_done;
        launch(fcs_pkg::CMD_BLANK, 32'h0);
        wait_done;
        rchk(fcs_pkg::ADDR_STATUS, 32'hC0);
        $display("blank test done");
    endtask
    task automatic t_protect;
        int s = starts;
        wr(fcs_pkg::ADDR_PROTECT, 32'h1);
        launch(fcs_pkg::CMD_PAGE_ERASE, 32'h0002_0000);
        rchk(fcs_pkg::ADDR_STATUS, 32'hE0);
        chk(32'(starts), 32'(s));
        wr(fcs_pkg::ADDR_STATUS, 32'h00);
        rchk(fcs_pkg::ADDR_STATUS, 32'hE0);
        wr(fcs_pkg::ADDR_STATUS, 32'h20);
        rchk(fcs_pkg::ADDR_STATUS, 32'hC0);
        launch(fcs_pkg::CMD_PAGE_ERASE, 32'h0);
        wait_done;
        chk(32'(starts), 32'(s + 1));
        $display("protect test done");
    endtask
    task automatic t_burst_stop;
        int s = starts;
        wr(fcs_pkg::ADDR_IRQ_STATUS, 32'h7);
        launch(fcs_pkg::CMD_BURST_PROG, 32'h0001_0011);
        launch(fcs_pkg::CMD_BURST_PROG, 32'h0001_0122);
        rchk(fcs_pkg::ADDR_STATUS, 32'h00);
        wait_done;
        chk(32'(starts), 32'(s + 2));
        // the buffered burst must carry the second target to the array
        chk({24'h0, acmd}, {24'h0, fcs_pkg::CMD_BURST_PROG});
        chk({24'h0, adata}, 32'h22);
        chk({18'h0, aaddr}, 32'h101);
        rchk(fcs_pkg::ADDR_IRQ_STATUS, 32'h1);
        launch(fcs_pkg::CMD_BYTE_PROG, 32'h0001_0233);
        stop <= 1'b1;
        wait_done;
        stop <= 1'b0;
        rchk(fcs_pkg::ADDR_STATUS, 32'hD0);
        $display("burst and stop test done");
    endtask
    initial begin
        repeat (16) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        t_reset;
        t_errors;
        t_blank;
        t_protect;
        t_burst_stop;
        give_verdict;
    end
    // a hang is cut off well past the several hundred cycles the tests need
    initial begin
        #300us;
        bad_count++;
        give_verdict;
    end
endmodule
